// ===== src/afe_consts.svh
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_REF_BIAS_CFG 8'h03
`define IDX_DISC_CTRL 8'h04
`define IDX_CH1_SET 8'h05
`define IDX_CH8_SET 8'h0c
`define IDX_BIAS_POS_SEL 8'h0d

// Reset values
`define RST_REF_BIAS_CFG 8'h40
`define RST_DISC_CTRL 8'h00
`define RST_CH_SET 8'h00
`define RST_BIAS_POS_SEL 8'h00

// Reference and bias-drive configuration fields
`define REF_BUF_EN_BIT 7
`define REF_RSVD_BIT 6
`define REF_HIGH_BIT 5
`define REF_MEAS_BIT 4
`define REF_INT_BIT 3
`define REF_BIASBUF_BIT 2
`define REF_SENSE_BIT 1
`define REF_STAT_BIT 0

// Electrode-disconnect control fields
`define DISC_TH_HI 7
`define DISC_TH_LO 5
`define DISC_METHOD_BIT 4
`define DISC_MAG_HI 3
`define DISC_MAG_LO 2
`define DISC_FREQ_HI 1
`define DISC_FREQ_LO 0

// Channel settings fields
`define CH_PD_BIT 7
`define CH_GAIN_HI 6
`define CH_GAIN_LO 4
`define CH_SEL_HI 2
`define CH_SEL_LO 0

// Detection frequency codes
`define FREQ_AC 2'h1
`define FREQ_BAD 2'h2
`define FREQ_DC 2'h3

// Excitation step in nA and full scale in tenths of a percent
`define EXC_STEP_NA 8'h06
`define PCT_FULL 10'h3e8

`endif

// ===== src/afe_pkg.sv
package afe_pkg;

   // Channel input selection codes
   typedef enum logic [2:0] {
      SEL_ELECTRODE = 3'h0,
      SEL_SHORTED = 3'h1,
      SEL_BIAS_MEAS = 3'h2,
      SEL_SUPPLY = 3'h3,
      SEL_TEMP = 3'h4,
      SEL_TEST = 3'h5,
      SEL_BIAS_POS = 3'h6,
      SEL_BIAS_NEG = 3'h7
   } input_select_t;

   // Reference and bias-drive controls towards the analogue side
   typedef struct packed {
      logic reference_buffer_enable;
      logic high_reference_select;
      logic bias_measure_route;
      logic bias_reference_internal;
      logic bias_buffer_enable;
      logic bias_sense_enable;
   } ref_ctrl_t;

   // Electrode-disconnect detection controls
   typedef struct packed {
      logic [9:0] threshold_pos_permille;
      logic [9:0] threshold_neg_permille;
      logic resistor_mode;
      logic [7:0] excitation_na;
      logic ac_detect;
      logic dc_detect;
      logic freq_forbidden;
   } disc_ctrl_t;

   // Per-channel controls
   typedef struct packed {
      logic power_down;
      logic [3:0] gain;
      input_select_t input_select;
      logic bias_meas_connect;
      logic bias_pos_derive;
   } chan_ctrl_t;

endpackage

// ===== src/afe_channel_bias_config_regs.sv
// Behaviour
// - reference config at 03h, resets 40h
// - bit 7 enables reference buffer
// - bit 5 selects 4 V reference
// - bit 4 routes bias input, code 010
// - bit 3 selects internal bias reference
// - bit 2 powers bias-drive buffer
// - bit 1 enables bias-drive sense
// - bit 0 read-only disconnect status
// - disconnect control at 04h, resets 00h
// - bits 7:5 comparator thresholds 95..70%
// - bit 4 current source or resistors
// - bits 3:2 excitation 6 to 24 nA
// - bits 1:0 AC quarter rate, DC; 10 forbidden
// - channel registers 05h..0Ch, reset 00h
// - bit 7 powers channel down
// - gain codes 6,1,2,3,4,8,12
// - input selection decode, eight codes
// - derivation select at 0Dh, per-channel route
// - upper derivation bits absent on small variants
`timescale 1ns/1ps
`include "afe_consts.svh"

module afe_channel_bias_config_regs
   import afe_pkg::*;
#(
   parameter int NUM_CHANNELS = 8,
   parameter int ADDR_WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analogue status in
   input wire logic bias_disconnect_in,
   input wire logic any_disconnect_sense,
   // Analogue controls out
   output ref_ctrl_t ref_ctrl,
   output disc_ctrl_t disc_ctrl,
   output chan_ctrl_t [7:0] chan_ctrl
);

   // Register storage
   // Reserved bits are plain storage so software reads back what it wrote
   logic [7:0] ref_cfg_reg;
   logic [7:0] disc_ctrl_reg;
   logic [7:0] chan_set_reg [8];
   logic [7:0] bias_pos_sel_reg;
   logic [7:0] ref_cfg_next;
   logic [7:0] bias_pos_sel_next;

   // Status synchroniser
   // Only the second flop is read; the first may still be settling
   logic stat_meta_reg;
   logic stat_sync_reg;

   // Bus response
   // Read data and error are registered in the setup cycle
   logic [31:0] rdata_reg;
   logic err_reg;
   logic [31:0] rd_value;
   logic rd_hit;
   logic wr_strobe;
   logic [7:0] wbyte;

   // Write-side address decode
   logic [7:0] addr_idx;
   logic hit_ref;
   logic hit_disc;
   logic hit_chan;
   logic hit_bias_pos;
   logic [7:0] chan_wr;

   // Mask of derivation bits that exist on this channel count
   // Six-channel parts lose bits 7:6, four-channel parts lose 5:4 as well
   localparam logic [7:0] CHAN_MASK =
      (NUM_CHANNELS <= 4) ? 8'h0f : (NUM_CHANNELS <= 6) ? 8'h3f : 8'hff;

   // Word index from a byte address; low two bits ignored
   // Sub-word byte addresses alias onto the same register
   function automatic logic [7:0] word_index(input logic [ADDR_WIDTH-1:0] a);
      logic [ADDR_WIDTH-1:0] w;
      w = a >> 2;
      return 8'(w);
   endfunction

   // True when the index falls on a channel settings register
   // The channel block is contiguous, so two compares cover it
   function automatic logic is_chan(input logic [7:0] idx);
      return (idx >= `IDX_CH1_SET) && (idx <= `IDX_CH8_SET);
   endfunction

   // Channel number from an index inside the channel range
   // Only meaningful where is_chan holds
   function automatic logic [2:0] chan_of(input logic [7:0] idx);
      logic [7:0] d;
      d = idx - `IDX_CH1_SET;
      return d[2:0];
   endfunction

   // Gain code to amplifier gain; reserved code 111 reads as zero gain
   // Zero is not a real gain, so the analogue side can spot the bad code
   function automatic logic [3:0] gain_of(input logic [2:0] code);
      case (code)
         3'h0: return 4'h6;
         3'h1: return 4'h1;
         3'h2: return 4'h2;
         3'h3: return 4'h3;
         3'h4: return 4'h4;
         3'h5: return 4'h8;
         3'h6: return 4'hc;
         default: return 4'h0;
      endcase
   endfunction

   // Positive comparator threshold in tenths of a percent
   // Integers let the analogue side load a DAC without its own table
   function automatic logic [9:0] thresh_pos(input logic [2:0] code);
      case (code)
         3'h0: return 10'h3b6;
         3'h1: return 10'h39d;
         3'h2: return 10'h384;
         3'h3: return 10'h36b;
         3'h4: return 10'h352;
         3'h5: return 10'h320;
         3'h6: return 10'h2ee;
         default: return 10'h2bc;
      endcase
   endfunction

   // Negative comparator threshold in tenths of a percent
   function automatic logic [9:0] thresh_neg(input logic [2:0] code);
      case (code)
         3'h0: return 10'h032;
         3'h1: return 10'h04b;
         3'h2: return 10'h064;
         3'h3: return 10'h07d;
         3'h4: return 10'h096;
         3'h5: return 10'h0c8;
         3'h6: return 10'h0fa;
         default: return 10'h12c;
      endcase
   endfunction

   // Excitation current in nA for the magnitude code
   // Only used in current-source mode; resistor mode forces zero
   function automatic logic [7:0] excite_of(input logic [1:0] code);
      case (code)
         2'h0: return 8'h06;
         2'h1: return 8'h0c;
         2'h2: return 8'h12;
         default: return 8'h18;
      endcase
   endfunction

   // Byte lane zero carries every register
   // A write with lane 0 off completes on the bus but changes nothing
   assign wbyte = pwdata[7:0];
   assign wr_strobe = psel && penable && pwrite && pstrb[0];

   // One decode of the word index shared by every write path
   assign addr_idx = word_index(paddr);
   assign hit_ref = (addr_idx == `IDX_REF_BIAS_CFG);
   assign hit_disc = (addr_idx == `IDX_DISC_CTRL);
   assign hit_chan = is_chan(addr_idx);
   assign hit_bias_pos = (addr_idx == `IDX_BIAS_POS_SEL);

   // One-hot write enable per channel register
   // Decoding here keeps the array index out of the clocked process
   always_comb begin
      chan_wr = 8'h00;
      if (wr_strobe && hit_chan) begin
         chan_wr[chan_of(addr_idx)] = 1'b1;
      end
   end

   // Two flops before the analogue status is used, it is asynchronous
   // A change shows in the register three edges later
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_meta_reg <= 1'b0;
         stat_sync_reg <= 1'b0;
      end else begin
         stat_meta_reg <= bias_disconnect_in;
         stat_sync_reg <= stat_meta_reg;
      end
   end

   // Written value for the reference register keeps the live status bit
   // Software cannot clear the status bit, not even for one cycle
   always_comb begin
      ref_cfg_next = wbyte;
      ref_cfg_next[`REF_STAT_BIT] = stat_sync_reg;
   end

   // Only derivation bits that exist on this variant can be set
   // Keeps the stored value clean so reads need no second mask
   assign bias_pos_sel_next = wbyte & CHAN_MASK;

   // Reference and bias-drive configuration register
   // Between writes the status bit follows the synchronised input
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_cfg_reg <= `RST_REF_BIAS_CFG;
      end else if (wr_strobe && hit_ref) begin
         ref_cfg_reg <= ref_cfg_next;
      end else begin
         ref_cfg_reg[`REF_STAT_BIT] <= stat_sync_reg;
      end
   end

   // Electrode-disconnect control register
   // Plain storage; decoding happens on the output side
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         disc_ctrl_reg <= `RST_DISC_CTRL;
      end else if (wr_strobe && hit_disc) begin
         disc_ctrl_reg <= wbyte;
      end
   end

   // Eight channel settings registers sharing one layout
   // Bit 3 is reserved but stored, so it reads back as written
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 8; i++) begin
            chan_set_reg[i] <= `RST_CH_SET;
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (chan_wr[i]) begin
               chan_set_reg[i] <= wbyte;
            end
         end
      end
   end

   // Positive-input bias derivation select register
   // Bits for channels this variant lacks are dropped on the way in
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bias_pos_sel_reg <= `RST_BIAS_POS_SEL;
      end else if (wr_strobe && hit_bias_pos) begin
         bias_pos_sel_reg <= bias_pos_sel_next;
      end
   end

   // Read multiplexer; unmapped indices flag an error and read zero
   // Reads have no side effects, so software may poll freely
   always_comb begin
      logic [7:0] idx;
      idx = word_index(paddr);
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      if (idx == `IDX_REF_BIAS_CFG) begin
         rd_value[7:0] = ref_cfg_reg;
      end else if (idx == `IDX_DISC_CTRL) begin
         rd_value[7:0] = disc_ctrl_reg;
      end else if (is_chan(idx)) begin
         rd_value[7:0] = chan_set_reg[chan_of(idx)];
      end else if (idx == `IDX_BIAS_POS_SEL) begin
         rd_value[7:0] = bias_pos_sel_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Response is captured in the setup cycle so prdata comes from a flop
   // Writes capture the miss flag too, so pslverr covers both directions
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (psel && !penable) begin
         rdata_reg <= pwrite ? 32'h0000_0000 : rd_value;
         err_reg <= !rd_hit;
      end
   end

   // Zero wait states; error only shown in the access phase
   // Every register is a flop, so nothing ever needs a wait state
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_reg;
   assign prdata = rdata_reg;

   // Reference and bias-drive controls
   // Bit 6 drives nothing; it is kept only for read-back
   assign ref_ctrl.reference_buffer_enable = ref_cfg_reg[`REF_BUF_EN_BIT];
   assign ref_ctrl.high_reference_select = ref_cfg_reg[`REF_HIGH_BIT];
   assign ref_ctrl.bias_measure_route = ref_cfg_reg[`REF_MEAS_BIT];
   assign ref_ctrl.bias_reference_internal = ref_cfg_reg[`REF_INT_BIT];
   assign ref_ctrl.bias_buffer_enable = ref_cfg_reg[`REF_BIASBUF_BIT];
   assign ref_ctrl.bias_sense_enable = ref_cfg_reg[`REF_SENSE_BIT];

   // Disconnect detection controls
   always_comb begin
      logic [2:0] th;
      logic [1:0] mag;
      logic [1:0] fr;
      th = disc_ctrl_reg[`DISC_TH_HI:`DISC_TH_LO];
      mag = disc_ctrl_reg[`DISC_MAG_HI:`DISC_MAG_LO];
      fr = disc_ctrl_reg[`DISC_FREQ_HI:`DISC_FREQ_LO];
      // Two separate tables, so a slip in one shows up against the other
      disc_ctrl.threshold_pos_permille = thresh_pos(th);
      disc_ctrl.threshold_neg_permille = thresh_neg(th);
      disc_ctrl.resistor_mode = disc_ctrl_reg[`DISC_METHOD_BIT];
      // Current only flows in current-source mode
      disc_ctrl.excitation_na = disc_ctrl_reg[`DISC_METHOD_BIT] ? 8'h00 : excite_of(mag);
      disc_ctrl.ac_detect = (fr == `FREQ_AC);
      disc_ctrl.dc_detect = (fr == `FREQ_DC);
      // Flags code 10, or a sensed disconnect while detection is off (code 00); the hardware does not correct it
      disc_ctrl.freq_forbidden = (fr == `FREQ_BAD)
         || (any_disconnect_sense && !disc_ctrl.ac_detect && !disc_ctrl.dc_detect);
   end

   // Per-channel controls; channels beyond the variant stay powered down
   // Code 010 reaches the bias input only while the measure route is on
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         logic [2:0] sel;
         sel = chan_set_reg[i][`CH_SEL_HI:`CH_SEL_LO];
         chan_ctrl[i].power_down = chan_set_reg[i][`CH_PD_BIT] || (i >= NUM_CHANNELS);
         chan_ctrl[i].gain = gain_of(chan_set_reg[i][`CH_GAIN_HI:`CH_GAIN_LO]);
         chan_ctrl[i].input_select = input_select_t'(sel);
         chan_ctrl[i].bias_meas_connect =
            ref_cfg_reg[`REF_MEAS_BIT] && (input_select_t'(sel) == SEL_BIAS_MEAS);
         chan_ctrl[i].bias_pos_derive = bias_pos_sel_reg[i];
      end
   end

endmodule

// ===== tb/afe_regs_assertions.sv
`timescale 1ns/1ps
module afe_regs_assertions
   import afe_pkg::*;
#(
   parameter int NUM_CHANNELS = 8,
   parameter int ADDR_WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Analogue side
   input wire logic bias_disconnect_in,
   input wire logic any_disconnect_sense,
   input wire ref_ctrl_t ref_ctrl,
   input wire disc_ctrl_t disc_ctrl,
   input wire chan_ctrl_t [7:0] chan_ctrl
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Accepted write and word index
   logic wr;
   logic [ADDR_WIDTH-3:0] idx;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign idx = paddr[ADDR_WIDTH-1:2];
   property p_ref;
      wr && idx == 3 |=> ref_ctrl == {$past(pwdata[7]), $past(pwdata[5:1])};
   endproperty
   a_ref: assert property (p_ref) else $error("ref controls wrong");
   property p_meas;
      chan_ctrl[0].bias_meas_connect == (ref_ctrl.bias_measure_route && chan_ctrl[0].input_select == SEL_BIAS_MEAS);
   endproperty
   a_meas: assert property (p_meas) else $error("bias measure route wrong");
   property p_thr;
      disc_ctrl.threshold_pos_permille + disc_ctrl.threshold_neg_permille == 10'h3e8;
   endproperty
   a_thr: assert property (p_thr) else $error("thresholds not paired");
   property p_disc;
      wr && idx == 4 |=> disc_ctrl.excitation_na == ($past(pwdata[4]) ? 8'h00 :
         8'h06 * ({6'h0, $past(pwdata[3:2])} + 8'h01)) && disc_ctrl.dc_detect == ($past(pwdata[1:0]) == 2'h3);
   endproperty
   a_disc: assert property (p_disc) else $error("disconnect controls wrong");
   property p_ch;
      wr && idx == 5 |=> chan_ctrl[0].power_down == $past(pwdata[7]) && chan_ctrl[0].input_select == $past(pwdata[2:0]);
   endproperty
   a_ch: assert property (p_ch) else $error("channel controls wrong");
   property p_der;
      wr && idx == 13 |=> chan_ctrl[NUM_CHANNELS-1].bias_pos_derive == $past(pwdata[NUM_CHANNELS-1]);
   endproperty
   a_der: assert property (p_der) else $error("derivation route wrong");
   property p_err;
      psel && penable |-> pready && pslverr == (idx < 3 || idx > 13);
   endproperty
   a_err: assert property (p_err) else $error("address decode wrong");
   property p_stat;
      $stable(bias_disconnect_in)[*4] ##0 (psel && !penable && !pwrite && idx == 3)
         |=> prdata[0] == $past(bias_disconnect_in);
   endproperty
   a_stat: assert property (p_stat) else $error("status bit wrong");
   property p_rst;
      $rose(reset_n) |-> ref_ctrl == '0 && disc_ctrl.excitation_na == 8'h06 && chan_ctrl[0].gain == 4'h6;
   endproperty
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
endmodule
bind afe_channel_bias_config_regs afe_regs_assertions #(.NUM_CHANNELS(NUM_CHANNELS), .ADDR_WIDTH(ADDR_WIDTH)) i_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .bias_disconnect_in(bias_disconnect_in), .any_disconnect_sense(any_disconnect_sense),
   .ref_ctrl(ref_ctrl), .disc_ctrl(disc_ctrl), .chan_ctrl(chan_ctrl));

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   import afe_pkg::*;
   // Bench signals and byte-wide register model
   logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic bias_disconnect_in = 0, any_disconnect_sense = 0;
   logic [7:0] paddr = 8'h00, m[16];
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic [5:0] ri;
   logic [3:0] pstrb = 4'h0;
   ref_ctrl_t ref_ctrl;
   disc_ctrl_t disc_ctrl;
   chan_ctrl_t [7:0] chan_ctrl;
   int err_count = 0, check_count = 0;
   int gt[8] = '{6, 1, 2, 3, 4, 8, 12, 0};
   int tt[8] = '{950, 925, 900, 875, 850, 800, 750, 700};
   afe_channel_bias_config_regs i_afe_channel_bias_config_regs (.sys_clk(sys_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bias_disconnect_in(bias_disconnect_in),
      .any_disconnect_sense(any_disconnect_sense), .ref_ctrl(ref_ctrl), .disc_ctrl(disc_ctrl),
      .chan_ctrl(chan_ctrl));
   // 20 MHz clock
   initial forever #25 sys_clk = ~sys_clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One APB transfer, then an idle cycle so no signal is driven twice in one step
   task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] dd, input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= dd;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      // Status bit survives writes; lane 0 strobe gates the write
      if (w && s[0] && i inside {[3:13]}) m[i] = i == 3 ? {dd[7:1], m[3][0]} : dd[7:0];
   endtask
   task automatic rdc(input logic [5:0] i);
      logic ok;
      ok = i inside {[3:13]};
      apb(1'b0, i, 32'h0, 4'h0);
      chk("rdata", rd, ok ? {24'h0, m[i]} : 32'h0);
      chk("pslverr", er, !ok);
   endtask
   task automatic outs;
      logic [1:0] f;
      f = m[4][1:0];
      chk("ref_ctrl", ref_ctrl, {m[3][7], m[3][5:1]});
      chk("disc_ctrl", disc_ctrl, {10'(tt[m[4][7:5]]), 10'(1000 - tt[m[4][7:5]]), m[4][4],
         m[4][4] ? 8'h00 : 8'(6 * (m[4][3:2] + 1)), f == 2'h1, f == 2'h3,
         f == 2'h2 || (f == 2'h0 && any_disconnect_sense)});
      for (int c = 0; c < 8; c++) chk("chan_ctrl", chan_ctrl[c], {m[5+c][7], 4'(gt[m[5+c][6:4]]), m[5+c][2:0],
         m[3][4] && m[5+c][2:0] == 3'h2, m[13][c]});
   endtask
   // Reset, then read indices 0 to 15 including unmapped ones
   task automatic rst_scan;
      reset_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      m = '{default: 8'h00};
      m[3] = 8'h40;
      @(posedge sys_clk);
      for (int i = 0; i < 16; i++) rdc(i);
      outs();
   endtask
   initial begin
      void'($urandom(79));
      rst_scan();
      $display("test reset done");
      // Every code of every field, status bit written as one
      for (int k = 0; k < 8; k++) begin
         any_disconnect_sense <= k[1];
         apb(1'b1, 5 + k, {k[0], k[2:0], 1'b0, k[2:0]}, 4'h1);
         apb(1'b1, 4, {k[2:0], k[0], k[1:0], k[1:0]}, 4'h1);
         apb(1'b1, 3, {k[0], 1'b1, k[2], k[1], ~k[0], k[1], k[2], 1'b1}, 4'h1);
         apb(1'b1, 13, 8'h1 << k, 4'h1);
         for (int i = 3; i < 14; i++) rdc(i);
         outs();
      end
      // Powered-down channels parked on the shorted input
      for (int c = 0; c < 8; c++) apb(1'b1, 5 + c, 32'h81, 4'h1);
      outs();
      $display("test codes done");
      // Status tracks the bias disconnect input, writes cannot clear it
      bias_disconnect_in <= 1'b1;
      repeat (5) @(posedge sys_clk);
      m[3][0] = 1'b1;
      rdc(3);
      apb(1'b1, 3, 32'h40, 4'h1);
      rdc(3);
      bias_disconnect_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
      m[3][0] = 1'b0;
      rdc(3);
      $display("test status done");
      for (int n = 0; n < 300; n++) begin
         any_disconnect_sense <= 1'($urandom);
         ri = 6'($urandom % 16);
         d = $urandom;
         if (ri == 3) d[6] = 1'b1;
         apb(1'b1, ri, d, 4'($urandom));
         rdc(ri);
         outs();
      end
      $display("test random done");
      rst_scan();
      $display("test second reset done");
      report_and_stop();
   end
endmodule
